// >>> src/ham_regs.vh
// constants for the alarm manager: alarm numbers, timing counts, temperature steps
// assumes a 25 MHz core clock and temperatures in tenths of a degree, signed 16 bit
//
// Behaviour
// - frost contact open raises heater frost alarm
// - frost alarm stops unit, valve fully open
// - frost clears after contact closes, manual or automatic
// - motor contact open raises alarm, stops unit
// - motor alarm clears on start or clear
// - pressure contact open past delay raises alarm
// - pressure alarm clears on start or clear
// - fire contact open raises alarm, stops unit
// - fire clears by button only, no autostart
// - overheat kills heaters, clears when contact closes
// - exchanger below limit opens bypass, unit runs
// - exchanger alarm clears above limit plus hysteresis
// - chiller contact closed raises alarm, cooling off
// - chiller clears by button, timeout, or restart
// - filter contact closed raises alarm, auto clear
// - main sensor open or short raises alarm
// - circuit one pressure alarms stop compressor one
// - circuit two pressure alarms stop compressor two
// - leak stops evaporator only when enabled
// - clear button ignored without valid login
// - setpoint moves in fixed half degree steps
// - login lasts in menu plus one minute
`ifndef HAM_REGS_VH
`define HAM_REGS_VH

// ==========================================================
// alarm numbers, bit index in the 32 bit active vector
`define HAM_AL_FROST      1
`define HAM_AL_MOTOR      2
`define HAM_AL_PRES1      3
`define HAM_AL_PRES2      4
`define HAM_AL_FIRE       5
`define HAM_AL_HITEMP     6
`define HAM_AL_EXCH       7
`define HAM_AL_CHILL      8
`define HAM_AL_FILTER     10
`define HAM_AL_SENSOR     20
`define HAM_AL_LP1        22
`define HAM_AL_HP1        23
`define HAM_AL_LEAK       24
`define HAM_AL_LP2        25
`define HAM_AL_HP2        26

// ==========================================================
// timing
`define HAM_CLK_HZ        25000000
`define HAM_TICK_CYC      25000
`define HAM_CHILL_MIN     5
`define HAM_CHILL_MS      (`HAM_CHILL_MIN * 60 * 1000)
`define HAM_LOGIN_MIN     1
`define HAM_LOGIN_MS      (`HAM_LOGIN_MIN * 60 * 1000)

// ==========================================================
// temperatures in tenths of a degree, plus the full heater valve force
`define HAM_EXCH_HYST     16'h000a
`define HAM_SP_STEP       16'h0005
`define HAM_SP_RESET      16'h00dc
`define HAM_VALVE_FULL    8'h64

`endif

// >>> src/ham_sync.v
// three stage synchroniser with agreement filter for the contact inputs
// assumes inputs are asynchronous levels from field wiring
`timescale 1ns/1ps
module ham_sync #(
    parameter W = 8
) (
    // clock and reset
    input  wire         core_clk,
    input  wire         rstn,
    // levels
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // first stage feeds only the second; output moves when stages two and three agree
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q     <= {W{1'b0}};
            s2_q     <= {W{1'b0}};
            s3_q     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            s1_q     <= async_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
        end
    end
endmodule

// >>> src/ham_alarm_mgr.v
// alarm supervision for an air handling unit controller
// assumes contacts are 1 when closed, sensors already digitised on core_clk
`timescale 1ns/1ps
`include "ham_regs.vh"
module ham_alarm_mgr #(
    parameter [31:0] TICK_CYC    = `HAM_TICK_CYC,
    parameter [31:0] CHILL_MS    = `HAM_CHILL_MS,
    parameter [31:0] LOGIN_MS    = `HAM_LOGIN_MS,
    parameter [15:0] PRES_MS_MAX = 16'hffff
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rstn,
    // field contacts, 1 = closed, asynchronous
    input  wire        frost_contact,
    input  wire        motor_fault_contact,
    input  wire        fan_pressure_contact,
    input  wire        filter_contact,
    input  wire        chiller_fault_contact,
    input  wire        fire_contact,
    input  wire        overheat_contact,
    // sensors and refrigerant faults, same clock domain
    input  wire        main_temp_open,
    input  wire        main_temp_short,
    input  wire [15:0] exch_temp,
    input  wire        lp1_fault,
    input  wire        hp1_fault,
    input  wire        lp2_fault,
    input  wire        hp2_fault,
    input  wire        leak_fault,
    // configuration
    input  wire        frost_clear_mode,
    input  wire [15:0] pressure_guard_delay,
    input  wire [15:0] exchanger_frost_limit,
    input  wire        leak_shutdown_enable,
    // operator panel, one cycle pulses except the in_menu level
    input  wire        clear_btn,
    input  wire        start_cmd,
    input  wire        stop_cmd,
    input  wire        login_ok,
    input  wire        in_menu,
    input  wire        sp_up,
    input  wire        sp_down,
    // status and actions
    output reg  [31:0] alarm_active,
    output reg         unit_run,
    output reg         unit_stop_alarm,
    output reg  [7:0]  heater_valve_force,
    output reg         heaters_off,
    output reg         bypass_open,
    output reg         cooling_off,
    output reg         comp1_off,
    output reg         comp2_off,
    output reg         evap_off,
    output reg         login_valid,
    output reg  [15:0] temp_setpoint
);

    // ==========================================================
    // contact synchronisers
    wire [6:0] c_s;
    ham_sync #(.W(7)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({overheat_contact, fire_contact, chiller_fault_contact, filter_contact,
                    fan_pressure_contact, motor_fault_contact, frost_contact}),
        .sync_out (c_s)
    );
    wire frost_cl  = c_s[0];
    wire motor_cl  = c_s[1];
    wire pres_cl   = c_s[2];
    wire filt_cl   = c_s[3];
    wire chill_cl  = c_s[4];
    wire fire_cl   = c_s[5];
    wire hot_cl    = c_s[6];

    // ==========================================================
    // millisecond tick divider
    reg  [31:0] tick_cnt_q;
    reg         tick_q;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYC - 32'h1) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q     <= 1'b0;
        end
    end

    // ==========================================================
    // login validity: held in menu, one minute grace after leaving
    reg [31:0] login_cnt_q;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            login_valid <= 1'b0;
            login_cnt_q <= 32'h0;
        end else if (login_ok) begin
            login_valid <= 1'b1;
            login_cnt_q <= 32'h0;
        end else if (in_menu) begin
            login_cnt_q <= 32'h0;
        end else if (login_valid && tick_q) begin
            if (login_cnt_q >= LOGIN_MS - 32'h1) begin
                login_valid <= 1'b0;
                login_cnt_q <= 32'h0;
            end else begin
                login_cnt_q <= login_cnt_q + 32'h1;
            end
        end
    end

    // valid clear only with a live login
    wire clr = clear_btn & login_valid;

    // ==========================================================
    // fan pressure open-time guard, counted in milliseconds
    reg [15:0] pres_cnt_q;
    reg        pres_trip_q;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pres_cnt_q  <= 16'h0;
            pres_trip_q <= 1'b0;
        end else if (pres_cl) begin
            pres_cnt_q  <= 16'h0;
            pres_trip_q <= 1'b0;
        end else if (tick_q) begin
            if (pres_cnt_q >= pressure_guard_delay) begin
                pres_trip_q <= 1'b1;
            end else if (pres_cnt_q != PRES_MS_MAX) begin
                pres_cnt_q <= pres_cnt_q + 16'h1;
            end
        end
    end

    // ==========================================================
    // chiller age timer, running from the moment the alarm is raised
    reg [31:0] chill_cnt_q;
    reg        chill_aged_q;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            chill_cnt_q  <= 32'h0;
            chill_aged_q <= 1'b0;
        end else if (!alarm_active[`HAM_AL_CHILL]) begin
            chill_cnt_q  <= 32'h0;
            chill_aged_q <= 1'b0;
        end else if (tick_q && !chill_aged_q) begin
            if (chill_cnt_q >= CHILL_MS - 32'h1) begin
                chill_aged_q <= 1'b1;
            end else begin
                chill_cnt_q <= chill_cnt_q + 32'h1;
            end
        end
    end

    // ==========================================================
    // exchanger temperature compares, signed tenths
    wire signed [15:0] t_ex    = exch_temp;
    wire signed [15:0] t_lim   = exchanger_frost_limit;
    wire signed [16:0] t_ex_w  = {t_ex[15], t_ex};
    wire signed [16:0] t_rel   = {t_lim[15], t_lim} + {1'b0, `HAM_EXCH_HYST};
    wire               ex_low  = t_ex < t_lim;
    // both sides signed, else a frosty outlet below zero reads as warm and clears
    wire               ex_high = t_ex_w > t_rel;

    // restart seen: start while the unit is stopped
    wire restart = start_cmd & ~unit_run;

    // ==========================================================
    // alarm latches: set wins over clear in the same cycle
    reg [31:0] set_v;
    reg [31:0] clr_v;
    always @* begin
        set_v = 32'h0;
        clr_v = 32'h0;
        set_v[`HAM_AL_FROST]  = ~frost_cl;
        clr_v[`HAM_AL_FROST]  = frost_cl & (frost_clear_mode | clr);
        set_v[`HAM_AL_MOTOR]  = ~motor_cl;
        clr_v[`HAM_AL_MOTOR]  = motor_cl & (start_cmd | clr);
        set_v[`HAM_AL_PRES1]  = pres_trip_q;
        clr_v[`HAM_AL_PRES1]  = pres_cl & (start_cmd | clr);
        set_v[`HAM_AL_FIRE]   = ~fire_cl;
        clr_v[`HAM_AL_FIRE]   = fire_cl & clr;
        set_v[`HAM_AL_HITEMP] = ~hot_cl;
        clr_v[`HAM_AL_HITEMP] = hot_cl;
        set_v[`HAM_AL_EXCH]   = ex_low;
        clr_v[`HAM_AL_EXCH]   = ex_high;
        set_v[`HAM_AL_CHILL]  = chill_cl;
        clr_v[`HAM_AL_CHILL]  = ~chill_cl & (clr | chill_aged_q | restart);
        set_v[`HAM_AL_FILTER] = filt_cl;
        clr_v[`HAM_AL_FILTER] = ~filt_cl;
        set_v[`HAM_AL_SENSOR] = main_temp_open | main_temp_short;
        clr_v[`HAM_AL_SENSOR] = ~(main_temp_open | main_temp_short);
        set_v[`HAM_AL_LP1]    = lp1_fault;
        clr_v[`HAM_AL_LP1]    = ~lp1_fault;
        set_v[`HAM_AL_HP1]    = hp1_fault;
        clr_v[`HAM_AL_HP1]    = ~hp1_fault;
        set_v[`HAM_AL_LEAK]   = leak_fault;
        clr_v[`HAM_AL_LEAK]   = ~leak_fault;
        set_v[`HAM_AL_LP2]    = lp2_fault;
        clr_v[`HAM_AL_LP2]    = ~lp2_fault;
        set_v[`HAM_AL_HP2]    = hp2_fault;
        clr_v[`HAM_AL_HP2]    = ~hp2_fault;
    end

    // latched flags; the shared pressure input also drives the extract alarm
    wire [31:0] act_d = set_v | (alarm_active & ~clr_v);
    wire        stop_al = act_d[`HAM_AL_FROST] | act_d[`HAM_AL_MOTOR] |
                          act_d[`HAM_AL_PRES1] | act_d[`HAM_AL_FIRE];
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            alarm_active <= 32'h0;
        end else begin
            alarm_active                 <= act_d;
            alarm_active[`HAM_AL_PRES2]  <= act_d[`HAM_AL_PRES1];
        end
    end

    // ==========================================================
    // unit run state: a stopping alarm forces off, a fresh start is needed after
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            unit_run        <= 1'b0;
            unit_stop_alarm <= 1'b0;
        end else begin
            unit_stop_alarm <= stop_al;
            if (stop_al || stop_cmd) begin
                unit_run <= 1'b0;
            end else if (start_cmd) begin
                unit_run <= 1'b1;
            end
        end
    end

    // ==========================================================
    // protective actions, registered from the next flag state
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            heater_valve_force <= 8'h0;
            heaters_off        <= 1'b0;
            bypass_open        <= 1'b0;
            cooling_off        <= 1'b0;
            comp1_off          <= 1'b0;
            comp2_off          <= 1'b0;
            evap_off           <= 1'b0;
        end else begin
            heater_valve_force <= act_d[`HAM_AL_FROST] ? `HAM_VALVE_FULL : 8'h0;
            heaters_off        <= act_d[`HAM_AL_HITEMP];
            bypass_open        <= act_d[`HAM_AL_EXCH];
            cooling_off        <= act_d[`HAM_AL_CHILL];
            comp1_off          <= act_d[`HAM_AL_LP1] | act_d[`HAM_AL_HP1];
            comp2_off          <= act_d[`HAM_AL_LP2] | act_d[`HAM_AL_HP2];
            evap_off           <= act_d[`HAM_AL_LEAK] & leak_shutdown_enable;
        end
    end

    // ==========================================================
    // setpoint editing in half degree steps; up wins if both arrive
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            temp_setpoint <= `HAM_SP_RESET;
        end else if (sp_up) begin
            temp_setpoint <= temp_setpoint + `HAM_SP_STEP;
        end else if (sp_down) begin
            temp_setpoint <= temp_setpoint - `HAM_SP_STEP;
        end
    end

endmodule

// >>> verif/ham_alarm_checker.sv
// concurrent checks on the alarm manager outputs, bound to every instance
// assumes the top ports as declared; the body is never looked into
`timescale 1ns/1ps
module ham_alarm_checker (
    // clock and reset
    input logic        core_clk,
    input logic        rstn,
    // panel and configuration
    input logic        clear_btn,
    input logic        start_cmd,
    input logic        leak_shutdown_enable,
    // status and actions
    input logic [31:0] alarm_active,
    input logic        unit_run,
    input logic        unit_stop_alarm,
    input logic [7:0]  heater_valve_force,
    input logic        heaters_off,
    input logic        bypass_open,
    input logic        cooling_off,
    input logic        comp1_off,
    input logic        comp2_off,
    input logic        evap_off,
    input logic        login_valid
);
    // ==========================================================
    // alarm groups sharing one action
    wire stop_al = alarm_active[1] | alarm_active[2] | alarm_active[3] | alarm_active[5];
    wire c1_al   = alarm_active[22] | alarm_active[23];
    wire c2_al   = alarm_active[25] | alarm_active[26];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // actions follow an alarm held two cycles, slack for the output register
    chk_unit_stop: assert property (stop_al && $past(stop_al) |-> unit_stop_alarm && !unit_run)
        else $error("stop alarm while unit runs");
    chk_valve_open: assert property (alarm_active[1] && $past(alarm_active[1]) |->
        heater_valve_force == 8'h64) else $error("frost valve not full");
    chk_heat_kill: assert property (alarm_active[6] && $past(alarm_active[6]) |-> heaters_off)
        else $error("heaters on during overheat");
    chk_bypass_open: assert property (alarm_active[7] && $past(alarm_active[7]) |-> bypass_open)
        else $error("bypass shut during freeze");
    chk_cool_off: assert property (alarm_active[8] && $past(alarm_active[8]) |-> cooling_off)
        else $error("cooling on during chiller alarm");
    chk_comp_one: assert property (c1_al && $past(c1_al) |-> comp1_off)
        else $error("compressor one left on");
    chk_comp_two: assert property (c2_al && $past(c2_al) |-> comp2_off)
        else $error("compressor two left on");
    chk_leak_gate: assert property (alarm_active[24] && $past(alarm_active[24]) &&
        $stable(leak_shutdown_enable) |-> evap_off == leak_shutdown_enable)
        else $error("evaporator not gated by leak enable");
    // a refused clear must leave the fire alarm standing
    chk_clear_login: assert property (clear_btn && !login_valid && alarm_active[5] |=>
        alarm_active[5]) else $error("clear taken without login");
    chk_fire_manual: assert property ($fell(alarm_active[5]) |->
        $past(clear_btn && login_valid) || $past(clear_btn && login_valid, 2))
        else $error("fire alarm cleared without button");
    chk_run_start: assert property ($rose(unit_run) |-> $past(start_cmd) || $past(start_cmd, 2))
        else $error("unit started without start command");
endmodule

bind ham_alarm_mgr ham_alarm_checker i_ham_alarm_checker (.*);

// >>> verif/ham_field_model.sv
// field wiring of the shared guard inputs
// assumes guard levels come from the bench, 1 = contact closed
`timescale 1ns/1ps
module ham_field_model (
    // individual guards
    input  logic sup_g,
    input  logic ext_g,
    input  logic filt_a,
    input  logic filt_b,
    // shared contact inputs
    output logic fan_pressure_contact,
    output logic filter_contact
);
    // ==========================================================
    // fan guards in series: either one opening breaks the loop
    assign fan_pressure_contact = sup_g & ext_g;
    // filter guards in parallel: any closed guard closes the input
    assign filter_contact = filt_a | filt_b;
endmodule

// >>> verif/ham_alarm_mgr_tb.sv
// self-checking bench: driver queues expectations, monitor compares
// assumes ham_field_model feeds the shared fan and filter inputs
`timescale 1ns/1ps
module ham_alarm_mgr_tb;
    // ==========================================================
    // signals
    logic core_clk, rstn, frost_contact, motor_fault_contact, fire_contact, overheat_contact;
    logic chiller_fault_contact, sup_g, ext_g, filt_a, filt_b, fan_pressure_contact;
    logic filter_contact, main_temp_open, main_temp_short, lp1_fault, hp1_fault, lp2_fault;
    logic hp2_fault, leak_fault, frost_clear_mode, leak_shutdown_enable, clear_btn, start_cmd;
    logic stop_cmd, login_ok, in_menu, sp_up, sp_down, unit_run, unit_stop_alarm, heaters_off;
    logic bypass_open, cooling_off, comp1_off, comp2_off, evap_off, login_valid;
    logic [7:0]  heater_valve_force;
    logic [8:0]  cts;
    logic [15:0] exch_temp, pressure_guard_delay, exchanger_frost_limit, temp_setpoint;
    logic [31:0] alarm_active, seen;
    logic [33:0] nt;
    logic [33:0] q[$];
    int bad_count, num_checks, cycles, d;
    // contact scenario table: toggle mask, alarm after first toggle, after toggling back, clearing press
    logic [8:0]  tg[6] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h004, 9'h002};
    logic [31:0] ea[6] = '{32'h2, 32'h4, 32'h20, 32'h40, 32'h18, 32'h400};
    logic [31:0] eb[6] = '{32'h2, 32'h4, 32'h20, 32'h0, 32'h18, 32'h0};
    logic [5:0]  pb[6] = '{6'h01, 6'h02, 6'h01, 6'h00, 6'h01, 6'h00};
    logic [15:0] ofs[3] = '{16'hffff, 16'h0005, 16'h000b};
    int rbit[5] = '{22, 23, 25, 26, 24};
    string nm[3] = '{"alarm_active", "login_run", "temp_setpoint"};

    assign {frost_contact, motor_fault_contact, fire_contact, overheat_contact} = cts[8:5];
    assign {chiller_fault_contact, sup_g, ext_g, filt_a, filt_b} = cts[4:0];

    // short counts keep the chiller and login timers within a few hundred cycles
    ham_alarm_mgr #(.TICK_CYC(4), .CHILL_MS(20), .LOGIN_MS(10)) i_ham_alarm_mgr (.*);
    ham_field_model i_ham_field_model (.*);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ==========================================================
    // helpers
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task press(input [5:0] p);
        {stop_cmd, sp_down, sp_up, login_ok, start_cmd, clear_btn} <= p;
        @(posedge core_clk);
        {stop_cmd, sp_down, sp_up, login_ok, start_cmd, clear_btn} <= 6'h0;
        cyc(3);
    endtask
    // queued at the falling edge, taken by the monitor at the next rising edge
    task note(input [1:0] s, input [31:0] e);
        @(negedge core_clk);
        q.push_back({s, e});
        @(posedge core_clk);
    endtask
    task check(input [31:0] sv, input [31:0] ev, input [1:0] s);
        num_checks++;
        if (sv !== ev) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm[s], ev, sv);
        end
    endtask
    task conclude();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // monitor and hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
        if (q.size() > 0) begin
            nt = q.pop_front();
            seen = nt[33:32] == 2'h0 ? alarm_active : nt[33:32] == 2'h1 ?
                {30'h0, login_valid, unit_run} : {16'h0, temp_setpoint};
            check(seen, nt[31:0], nt[33:32]);
        end
    end

    // ==========================================================
    // stimulus
    initial begin
        void'($urandom(32'h695500f2));
        rstn = 1'b0;
        cts = 9'h1ec;
        {main_temp_open, main_temp_short, leak_shutdown_enable} = 3'h0;
        {leak_fault, hp2_fault, lp2_fault, hp1_fault, lp1_fault} = 5'h0;
        {stop_cmd, sp_down, sp_up, login_ok, start_cmd, clear_btn} = 6'h0;
        {frost_clear_mode, in_menu} = 2'h3;
        pressure_guard_delay = 16'h0003 + 16'($urandom_range(2));
        // limit just below zero so that limit plus half the hysteresis is still negative
        exchanger_frost_limit = 16'hfff6 + 16'($urandom_range(4));
        exch_temp = 16'h00c8;
        d = 4 * pressure_guard_delay;
        cyc(4);
        rstn <= 1'b1;
        cyc(12);
        note(0, 32'h24);
        press(6'h01);
        note(0, 32'h24);
        press(6'h04);
        press(6'h01);
        note(0, 32'h0);
        press(6'h02);
        note(1, 32'h3);
        frost_clear_mode <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            cts <= cts ^ tg[i];
            // the fan guard only trips after the pressure delay in ticks has run out
            cyc(i == 4 ? d + 16 : 8);
            note(0, ea[i]);
            cts <= cts ^ tg[i];
            cyc(8);
            note(0, eb[i]);
            press(pb[i]);
            note(0, 32'h0);
            press(6'h02);
            note(1, 32'h3);
        end
        // a dip shorter than the guard delay must not trip
        cts <= cts ^ 9'h008;
        cyc(d - 6);
        cts <= cts ^ 9'h008;
        cyc(8);
        note(0, 32'h0);
        for (int i = 0; i < 3; i++) begin
            exch_temp <= exchanger_frost_limit + ofs[i];
            cyc(4);
            note(0, i < 2 ? 32'h80 : 32'h0);
            note(1, 32'h3);
        end
        cts <= cts ^ 9'h010;
        cyc(8);
        note(0, 32'h100);
        cts <= cts ^ 9'h010;
        cyc(8);
        note(0, 32'h100);
        cyc(80);
        note(0, 32'h0);
        cts <= cts ^ 9'h010;
        cyc(8);
        cts <= cts ^ 9'h010;
        cyc(8);
        press(6'h20);
        press(6'h02);
        note(0, 32'h0);
        for (int i = 0; i < 3; i++) begin
            {main_temp_open, main_temp_short} <= 2'h2 >> i;
            cyc(3);
            note(0, i < 2 ? 32'h100000 : 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            leak_shutdown_enable <= (i >= 5);
            {leak_fault, hp2_fault, lp2_fault, hp1_fault, lp1_fault} <= 5'h1 << (i % 5);
            cyc(3);
            note(0, 32'h1 << rbit[i % 5]);
        end
        {leak_fault, hp2_fault, lp2_fault, hp1_fault, lp1_fault} <= 5'h0;
        press(6'h08);
        press(6'h08);
        press(6'h10);
        note(2, 32'h00e1);
        in_menu <= 1'b0;
        cyc(20);
        note(1, 32'h3);
        cyc(30);
        note(1, 32'h1);
        cts <= cts ^ 9'h040;
        cyc(8);
        cts <= cts ^ 9'h040;
        cyc(8);
        press(6'h01);
        note(0, 32'h20);
        cyc(2);
        conclude();
    end
endmodule
